// ---- logic/hdt_defs.svh ----
/*
 * Constants of the haptic duty translator: clock rate, switching period,
 * full-scale reference and measurement widths.
 * Assumes it is included by bare name from every file that needs a value.
 */
`ifndef HDT_DEFS_SVH
`define HDT_DEFS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define HDT_CLK_HZ 10000000
`define HDT_SW_FREQ_HZ 20300
`define HDT_SW_PERIOD_CYC (`HDT_CLK_HZ / `HDT_SW_FREQ_HZ)
`define HDT_SW_W 9
`define HDT_MAX_PERIOD_CYC 65535

// ==========================================================================
// Drive reference and widths
// ==========================================================================
`define HDT_FULL_SCALE_MV 3600
`define HDT_HALF_DUTY_PCT 50
`define HDT_PER_W 16
`define HDT_DIV_W 40
`define HDT_SUPPLY_W 13

`endif

// ---- logic/hdt_pkg.sv ----
/*
 * Types of the haptic duty translator: core state machine and its state record.
 * Assumes hdt_defs.svh supplies the widths.
 */
`include "hdt_defs.svh"
`default_nettype none

package hdt_pkg;

    // ======================================================================
    // Core state
    // ======================================================================
    typedef enum logic [0:0] {
        HDT_IDLE,
        HDT_ACTIVE
    } hdt_state_t;

    typedef struct packed {
        logic legA;
        logic legB;
    } hdt_bridge_t;

    typedef struct packed {
        hdt_state_t st;
        logic pwmPrev;
        logic [`HDT_PER_W-1:0] highCnt;
        logic [`HDT_PER_W-1:0] perCnt;
        logic [`HDT_PER_W-1:0] highLat;
        logic [`HDT_PER_W-1:0] perLat;
        logic divGo;
        logic sampFwd;
        logic [`HDT_SW_W-1:0] onCyc;
        logic [`HDT_SW_W-1:0] swCnt;
        logic [`HDT_SW_W-1:0] curOn;
        logic curFwd;
        hdt_bridge_t bridge;
    } hdt_core_t;

endpackage

`default_nettype wire

// ---- logic/hdt_divider.sv ----
/*
 * Sequential restoring divider, one quotient bit per clock.
 * Assumes start is only pulsed while the previous division is finished or
 * may be abandoned; a new start restarts the division.
 */
`include "hdt_defs.svh"
`default_nettype none

module hdt_divider #(
    parameter int W = `HDT_DIV_W
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic [W-1:0] quotient,
    output logic done
);

    localparam int CW = $clog2(W + 1);

    typedef struct packed {
        logic busy;
        logic [CW-1:0] cnt;
        logic [W-1:0] rem;
        logic [W-1:0] quo;
        logic [W-1:0] den;
        logic [W-1:0] res;
        logic done;
    } hdt_div_t;

    hdt_div_t cur_ff;
    hdt_div_t nxt_cur;

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        logic [W-1:0] remSh;
        remSh = '0;
        nxt_cur = cur_ff;
        nxt_cur.done = 1'b0;
        if (start) begin
            nxt_cur.busy = 1'b1;
            nxt_cur.cnt = '0;
            nxt_cur.rem = '0;
            nxt_cur.quo = dividend;
            nxt_cur.den = divisor;
        end else if (cur_ff.busy) begin
            remSh = {cur_ff.rem[W-2:0], cur_ff.quo[W-1]};
            nxt_cur.quo = {cur_ff.quo[W-2:0], 1'b0};
            if (remSh >= cur_ff.den) begin
                nxt_cur.rem = remSh - cur_ff.den;
                nxt_cur.quo[0] = 1'b1;
            end else begin
                nxt_cur.rem = remSh;
            end
            nxt_cur.cnt = cur_ff.cnt + CW'(1);
            if (cur_ff.cnt == CW'(W - 1)) begin
                nxt_cur.busy = 1'b0;
                nxt_cur.done = 1'b1;
                nxt_cur.res = nxt_cur.quo;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign quotient = cur_ff.res;
    assign done = cur_ff.done;

endmodule

`default_nettype wire

// ---- logic/haptic_duty_translator.sv ----
/*
 * Haptic duty translator: measures the host PWM duty, turns it into a signed,
 * supply-compensated switching duty and drives the two H-bridge legs.
 * Assumes pwmIn, enableIn, actuatorTypeSel, supplyMv, motionDetected and
 * resonancePhase are synchronous to sys_clk; supplyMv comes from a supply
 * monitor, motionDetected and resonancePhase from the back-EMF tracker.
 * The first period after enable is partial and may give one short-lived
 * drive level; a new input duty reaches the legs within one input period,
 * one divide and one switching period.
 */
`include "hdt_defs.svh"
`default_nettype none

module haptic_duty_translator #(
    parameter int MAX_PERIOD_CYC = `HDT_MAX_PERIOD_CYC,
    parameter int FULL_SCALE_MV = `HDT_FULL_SCALE_MV
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic pwmIn,
    input wire logic enableIn,
    input wire logic actuatorTypeSel,
    input wire logic [`HDT_SUPPLY_W-1:0] supplyMv,
    input wire logic motionDetected,
    input wire logic resonancePhase,
    output logic legA,
    output logic legB,
    output logic effectActive
);

    // Constants are sized here once so the arithmetic below neither pads nor truncates by accident.
    localparam logic [`HDT_SW_W-1:0] SW_PERIOD = `HDT_SW_W'(`HDT_SW_PERIOD_CYC);
    localparam logic [`HDT_PER_W-1:0] PER_LIMIT = `HDT_PER_W'(MAX_PERIOD_CYC - 1);
    localparam logic [`HDT_DIV_W-1:0] FS_MV = `HDT_DIV_W'(FULL_SCALE_MV);
    localparam logic [`HDT_DIV_W-1:0] SW_PER_W = `HDT_DIV_W'(`HDT_SW_PERIOD_CYC);

    hdt_pkg::hdt_core_t cur_ff;
    hdt_pkg::hdt_core_t nxt_cur;

    logic [`HDT_PER_W:0] twoHigh;
    logic [`HDT_PER_W:0] perExt;
    logic [`HDT_PER_W:0] diffMag;
    logic aboveHalf;
    logic resonantBrake;
    logic [`HDT_DIV_W-1:0] divNum;
    logic [`HDT_DIV_W-1:0] divDen;
    logic [`HDT_DIV_W-1:0] divQuot;
    logic divDone;
    logic [`HDT_SW_W-1:0] wrapOn;
    logic wrapFwd;

    // ======================================================================
    // Helpers
    // ======================================================================
    // Distance between two values; the sign is carried apart by aboveHalf.
    function automatic logic [`HDT_PER_W:0] absGap(
        input logic [`HDT_PER_W:0] a,
        input logic [`HDT_PER_W:0] b
    );
        return (a > b) ? a - b : b - a;
    endfunction

    // One step of the period and high-time counters.
    function automatic logic [`HDT_PER_W-1:0] countUp(input logic [`HDT_PER_W-1:0] v);
        return v + `HDT_PER_W'(1);
    endfunction

    // Quotients beyond one switching period saturate to a full-on pulse,
    // which also covers a supply reading of zero.
    function automatic logic [`HDT_SW_W-1:0] clampOn(input logic [`HDT_DIV_W-1:0] q);
        if (q > `HDT_DIV_W'(SW_PERIOD)) begin
            return SW_PERIOD;
        end
        return q[`HDT_SW_W-1:0];
    endfunction

    // Only one leg of the bridge may ever conduct.
    function automatic hdt_pkg::hdt_bridge_t legsFor(input logic isOn, input logic fwd);
        hdt_pkg::hdt_bridge_t b;
        b.legA = isOn && fwd;
        b.legB = isOn && !fwd;
        return b;
    endfunction

    // ======================================================================
    // Amplitude arithmetic
    // ======================================================================
    // Signed amplitude is FS*(2*high/period - 1), or -FS for a resonant actuator at or
    // below half; the sign and magnitude are kept apart so one unsigned divider serves both directions.
    always_comb begin
        twoHigh = {cur_ff.highLat, 1'b0};
        perExt = {1'b0, cur_ff.perLat};
        aboveHalf = twoHigh > perExt;
        resonantBrake = actuatorTypeSel && !aboveHalf;
        if (resonantBrake) begin
            diffMag = perExt;
        end else begin
            diffMag = absGap(twoHigh, perExt);
        end
    end

    // Duty in switching cycles = FS/Vdd * |2h/p - 1| * period (FS/Vdd * period for a resonant
    // brake), so the drive stays constant as the battery sags; the product fits the 40-bit path.
    assign divNum = `HDT_DIV_W'(diffMag) * FS_MV * SW_PER_W;
    assign divDen = `HDT_DIV_W'(cur_ff.perLat) * `HDT_DIV_W'(supplyMv);

    // A new sample restarts the divider, so input periods shorter than one
    // divide only postpone the update instead of mixing two samples.
    hdt_divider #(
        .W(`HDT_DIV_W)
    ) u_div (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(cur_ff.divGo),
        .dividend(divNum),
        .divisor(divDen),
        .quotient(divQuot),
        .done(divDone)
    );

    // ======================================================================
    // Drive taken at a switching period boundary
    // ======================================================================
    always_comb begin
        if (!actuatorTypeSel) begin
            wrapOn = cur_ff.onCyc;
            wrapFwd = cur_ff.sampFwd;
        end else if (cur_ff.sampFwd) begin
            wrapOn = cur_ff.onCyc;
            wrapFwd = resonancePhase;
        end else begin
            // Braking opposes the motion and stops once the
            // tracker reports rest, so no reverse ringing builds.
            wrapOn = motionDetected ? cur_ff.onCyc : '0;
            wrapFwd = !resonancePhase;
        end
    end

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        logic rise;
        logic onNow;
        rise = 1'b0;
        onNow = 1'b0;
        nxt_cur = cur_ff;
        nxt_cur.divGo = 1'b0;
        case (cur_ff.st)
            hdt_pkg::HDT_IDLE: begin
                nxt_cur = '0;
                nxt_cur.pwmPrev = pwmIn;
                if (enableIn) begin
                    nxt_cur.st = hdt_pkg::HDT_ACTIVE;
                end
            end
            hdt_pkg::HDT_ACTIVE: begin
                rise = pwmIn && !cur_ff.pwmPrev;
                nxt_cur.pwmPrev = pwmIn;
                // Period runs rising edge to rising edge; a line stuck for
                // the longest period counts as 0% or 100%.
                if (rise && cur_ff.perCnt != '0) begin
                    nxt_cur.highLat = cur_ff.highCnt;
                    nxt_cur.perLat = cur_ff.perCnt;
                    // Direction stays with the running drive until its new
                    // magnitude arrives, so a wrap during the divide keeps the pair.
                    nxt_cur.divGo = 1'b1;
                    nxt_cur.highCnt = `HDT_PER_W'(1);
                    nxt_cur.perCnt = `HDT_PER_W'(1);
                end else if (cur_ff.perCnt >= PER_LIMIT) begin
                    nxt_cur.highLat = pwmIn ? cur_ff.perCnt : '0;
                    nxt_cur.perLat = cur_ff.perCnt;
                    nxt_cur.divGo = 1'b1;
                    nxt_cur.highCnt = '0;
                    nxt_cur.perCnt = '0;
                end else begin
                    nxt_cur.perCnt = countUp(cur_ff.perCnt);
                    if (pwmIn) begin
                        nxt_cur.highCnt = countUp(cur_ff.highCnt);
                    end
                end
                if (divDone) begin
                    nxt_cur.sampFwd = aboveHalf;
                    nxt_cur.onCyc = clampOn(divQuot);
                end
                // New drive takes effect only at a switching period boundary,
                // which keeps every output pulse whole.
                if (cur_ff.swCnt >= SW_PERIOD - `HDT_SW_W'(1)) begin
                    nxt_cur.swCnt = '0;
                    nxt_cur.curOn = wrapOn;
                    nxt_cur.curFwd = wrapFwd;
                end else begin
                    nxt_cur.swCnt = cur_ff.swCnt + `HDT_SW_W'(1);
                end
                onNow = nxt_cur.swCnt < nxt_cur.curOn;
                nxt_cur.bridge = legsFor(onNow, nxt_cur.curFwd);
                // Dropping enable overrides everything above in the same
                // cycle, so the bridge is off one edge after enable falls.
                if (!enableIn) begin
                    nxt_cur = '0;
                    nxt_cur.st = hdt_pkg::HDT_IDLE;
                end
            end
            default: begin
                nxt_cur = '0;
            end
        endcase
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign legA = cur_ff.bridge.legA;
    assign legB = cur_ff.bridge.legB;
    assign effectActive = cur_ff.st == hdt_pkg::HDT_ACTIVE;

endmodule

`default_nettype wire

// ---- sim/hdt_checker.sv ----
/*
 * Checker watching the translator's pins.
 * Assumes it is bound into haptic_duty_translator.
 */
`default_nettype none

module hdt_checker #(
    parameter int MAX_PERIOD_CYC = 65535
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic pwmIn,
    input wire logic enableIn,
    input wire logic actuatorTypeSel,
    input wire logic motionDetected,
    input wire logic legA,
    input wire logic legB,
    input wire logic effectActive
);
    // A stuck line is seen after MAX_PERIOD_CYC, then a divide and one switching period follow.
    localparam int SETTLE = MAX_PERIOD_CYC + 1000;
    logic [16:0] lowCnt_ff, hiCnt_ff, quietCnt_ff;
    // The counters wrap after 131072 cycles, longer than any effect driven here.
    always_ff @(posedge sys_clk) begin
        lowCnt_ff <= (!rst_b || !effectActive || pwmIn) ? 17'h00000 : lowCnt_ff + 17'h00001;
        hiCnt_ff <= (!rst_b || !effectActive || !pwmIn) ? 17'h00000 : hiCnt_ff + 17'h00001;
        quietCnt_ff <= (!rst_b || !effectActive || pwmIn || motionDetected) ? 17'h00000 : quietCnt_ff + 17'h00001;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    a_legs_apart: assert property (!(legA && legB))
        else $error("both legs on");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b |=> !legA && !legB && !effectActive)
        else $error("outputs live after reset");
    a_disable_quiet: assert property (!enableIn [*2] |=> !legA && !legB && !effectActive)
        else $error("outputs live while disabled");
    a_enable_start: assert property (enableIn [*2] |=> effectActive)
        else $error("effect not started");
    a_idle_no_drive: assert property (!effectActive |-> !legA && !legB)
        else $error("legs driven while idle");
    a_zero_no_fwd: assert property (!actuatorTypeSel && lowCnt_ff >= SETTLE |-> !legA)
        else $error("forward drive at zero duty");
    a_full_no_rev: assert property (!actuatorTypeSel && hiCnt_ff >= SETTLE |-> !legB)
        else $error("reverse drive at full duty");
    a_brake_stops: assert property (actuatorTypeSel && quietCnt_ff >= SETTLE |-> !legA && !legB)
        else $error("drive after motion stopped");
    c_fwd: cover property (legA);
    c_rev: cover property (legB);
    c_stop: cover property (actuatorTypeSel && quietCnt_ff >= SETTLE);
endmodule

bind haptic_duty_translator hdt_checker #(.MAX_PERIOD_CYC(MAX_PERIOD_CYC)) chk (.sys_clk(sys_clk),
    .rst_b(rst_b), .pwmIn(pwmIn), .enableIn(enableIn), .actuatorTypeSel(actuatorTypeSel),
    .motionDetected(motionDetected), .legA(legA), .legB(legB), .effectActive(effectActive));

`default_nettype wire

// ---- sim/hdt_host_model.sv ----
/*
 * Host model: PWM source and enable line.
 * Assumes the bench sets runReq and the duty at the falling edge.
 */
`default_nettype none

module hdt_host_model (
    input wire logic sys_clk,
    input wire logic runReq,
    input wire logic [15:0] hiCyc,
    input wire logic [15:0] perCyc,
    output logic pwmOut,
    output logic enableOut
);
    logic [15:0] phaseCnt = 16'h0000;
    initial pwmOut = 1'b0;
    initial enableOut = 1'b0;
    // The PWM keeps running while disabled, as a host sharing its timer would.
    always @(negedge sys_clk) begin
        enableOut <= runReq;
        phaseCnt <= (phaseCnt >= perCyc - 16'h0001) ? 16'h0000 : phaseCnt + 16'h0001;
        pwmOut <= phaseCnt < hiCyc;
    end
endmodule

`default_nettype wire

// ---- sim/haptic_duty_translator_test.sv ----
/*
 * Self-checking bench of the haptic duty translator.
 * Assumes the host model drives pwmIn and enableIn with a 100-cycle period.
 */
`include "hdt_defs.svh"
`default_nettype none

module haptic_duty_translator_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SW = `HDT_SW_PERIOD_CYC;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic runReq = 1'b0;
    logic actuatorTypeSel = 1'b0;
    logic motionDetected = 1'b1;
    logic resonancePhase = 1'b1;
    logic [`HDT_SUPPLY_W-1:0] supplyMv = 13'h0E10;
    logic [15:0] hiCyc = 16'h0050;
    logic [15:0] perCyc = 16'h0064;
    logic pwmIn, enableIn, legA, legB, effectActive;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #50 sys_clk = ~sys_clk;

    hdt_host_model host (.sys_clk(sys_clk), .runReq(runReq), .hiCyc(hiCyc), .perCyc(perCyc),
        .pwmOut(pwmIn), .enableOut(enableIn));
    haptic_duty_translator #(.MAX_PERIOD_CYC(2000)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .pwmIn(pwmIn),
        .enableIn(enableIn), .actuatorTypeSel(actuatorTypeSel), .supplyMv(supplyMv),
        .motionDetected(motionDetected), .resonancePhase(resonancePhase), .legA(legA), .legB(legB),
        .effectActive(effectActive));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            $display("MISMATCH at %0t: run hung", $time);
            wrap_up();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        num_checks++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH at %0t: %s seen %0d expected %0d", $time, what, seen, want);
        end
    endtask

    // Expected on-time of one leg for duty h of 100 at the present supply.
    function automatic logic [15:0] expOn(input int h, input logic fwd);
        int diff;
        diff = fwd ? 2 * h - 100 : 100 - 2 * h;
        if (diff <= 0)
            return 16'h0000;
        diff = (`HDT_FULL_SCALE_MV * diff * SW) / (100 * int'(supplyMv));
        return 16'((diff > SW) ? SW : diff);
    endfunction

    // Long settle so that a stuck line is detected and a switching period wraps.
    task automatic runDuty(input int h, input logic [15:0] wantA, input logic [15:0] wantB);
        logic [15:0] onA;
        logic [15:0] onB;
        hiCyc <= 16'(h);
        onA = 16'h0000;
        onB = 16'h0000;
        repeat (3000) @(negedge sys_clk);
        repeat (SW) begin
            @(negedge sys_clk);
            onA = onA + {15'h0000, legA};
            onB = onB + {15'h0000, legB};
        end
        check(onA, wantA, "forward leg on-time");
        check(onB, wantB, "reverse leg on-time");
    endtask

    task automatic doReset(input logic sel);
        runReq <= 1'b0;
        rst_b <= 1'b0;
        actuatorTypeSel = sel;
        repeat (16) @(negedge sys_clk);
        rst_b <= 1'b1;
        @(negedge sys_clk);
        runReq <= 1'b1;
    endtask

    task automatic t_erm_levels();
        int duty[4] = '{100, 80, 50, 20};
        // The effect opens at full duty as a short overdrive; a full 20 ms would not fit the run.
        foreach (duty[i])
            runDuty(duty[i], expOn(duty[i], 1'b1), expOn(duty[i], 1'b0));
        $display("erm levels done");
    endtask

    task automatic t_supply();
        int vdd[2] = '{4800, 2500};
        foreach (vdd[i]) begin
            supplyMv = 13'(vdd[i]);
            runDuty(80, expOn(80, 1'b1), 16'h0000);
        end
        supplyMv = 13'h0E10;
        $display("supply compensation done");
    endtask

    task automatic t_disable();
        logic [15:0] seen;
        seen = 16'h0000;
        runReq <= 1'b0;
        // The host passes the request on one falling edge later and the core drops one rising edge after that.
        repeat (2) @(negedge sys_clk);
        repeat (1000) begin
            @(negedge sys_clk);
            seen = seen | {13'h0000, effectActive, legA, legB};
        end
        check(seen, 16'h0000, "activity while disabled");
        runReq <= 1'b1;
        repeat (3) @(negedge sys_clk);
        check({15'h0000, effectActive}, 16'h0001, "effect not active");
        $display("disable done");
    endtask

    // The brake lasts one settle only, so an actuator would not counter-rotate.
    task automatic t_brake();
        runDuty(0, 16'h0000, expOn(0, 1'b0));
        runReq <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check({13'h0000, effectActive, legA, legB}, 16'h0000, "outputs after end");
        $display("brake done");
    endtask

    task automatic t_resonant();
        doReset(1'b1);
        runDuty(80, expOn(80, 1'b1), 16'h0000);
        runDuty(20, 16'h0000, 16'(SW));
        resonancePhase = 1'b0;
        runDuty(30, 16'(SW), 16'h0000);
        motionDetected = 1'b0;
        runDuty(20, 16'h0000, 16'h0000);
        // A steady 0% with the actuator at rest lets the checker see a long quiet brake.
        runDuty(0, 16'h0000, 16'h0000);
        $display("resonant done");
    endtask

    initial begin
        doReset(1'b0);
        t_erm_levels();
        t_supply();
        t_disable();
        t_brake();
        t_resonant();
        wrap_up();
    end
endmodule

`default_nettype wire
